// File: rtl/module_clock_gating_defs.svh
// constants of the module clock gating block: addresses, bit positions, reset values
// assumes it is included by bare name from the package and the design module
`ifndef MODULE_CLOCK_GATING_DEFS_SVH
`define MODULE_CLOCK_GATING_DEFS_SVH

// ==========================================================
// addresses
`define MCG_CPU_BASE        32'h4001_0000
`define MCG_MCU_BASE        32'h000D_0000
`define MCG_GATE_OFS        32'h0000_0000
`define MCG_CPU_GATE_ADDR   (`MCG_CPU_BASE + `MCG_GATE_OFS)
`define MCG_MCU_GATE_ADDR   (`MCG_MCU_BASE + `MCG_GATE_OFS)

// ==========================================================
// gate bit positions
`define MCG_BIT_SERIAL0     0
`define MCG_BIT_SERIAL1     1
`define MCG_BIT_CAN0        2
`define MCG_BIT_CAN1        3
`define MCG_BIT_WATCHDOG    4
`define MCG_BIT_FIELDBUS_B  5
`define MCG_BIT_ETHER_SW    6
`define MCG_BIT_FIELDBUS_A  13
`define MCG_BIT_FIELDBUS_IE 14
`define MCG_GATE_W          15

// ==========================================================
// field masks and reset values
`define MCG_RSVD_HI_MASK    32'hFFFF_8000
`define MCG_RSVD_B12_MASK   32'h0000_1000
`define MCG_RSVD_ONES       32'h0000_0F80
`define MCG_IMPL_IE         32'h0000_605F
`define MCG_IMPL_B          32'h0000_207F
`define MCG_RESET_IE        32'h0000_6FDF
`define MCG_RESET_B         32'h0000_2FFF
`define MCG_ALL_ONES        32'hFFFF_FFFF

`endif

// File: rtl/module_clock_gating_pkg.sv
// types of the module clock gating block
// assumes the defs header sits in the include path
`include "module_clock_gating_defs.svh"

package module_clock_gating_pkg;

    // ==========================================================
    // register access carriers
    typedef struct packed {
        logic [31:0] addr;
        logic        wr;
        logic        rd;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic        ack;
    } reg_rsp_t;

    // ==========================================================
    // whole state of the block
    typedef struct packed {
        logic [31:0] gate;
        reg_rsp_t    cpu;
        reg_rsp_t    mcu;
    } gate_state_t;

endpackage

// File: rtl/module_clock_gating.sv
// gate register for the on-chip peripheral clocks, one enable per module
// assumes both access ports are synchronous to clk_i; sys_rst_i is the system reset
`timescale 1ns/1ps
`include "module_clock_gating_defs.svh"

module module_clock_gating #(
    parameter bit VARIANT_IE = 1'b1      // 1: bit-14 controller present, 0: bit-5 controller
) (
    input  wire logic                               clk_i,      // system clock, 50 MHz
    input  wire logic                               sys_rst_i,  // system reset, async high
    input  wire module_clock_gating_pkg::reg_req_t  cpu_req_i,  // on-chip cpu/dma access
    input  wire module_clock_gating_pkg::reg_req_t  mcu_req_i,  // external mcu access
    output module_clock_gating_pkg::reg_rsp_t       cpu_rsp_o,  // cpu/dma answer
    output module_clock_gating_pkg::reg_rsp_t       mcu_rsp_o,  // mcu answer
    output logic [`MCG_GATE_W-1:0]                  gate_en_o   // clock enables per bit
);

    // ==========================================================
    // variant constants
    localparam logic [31:0] IMPL_MASK = VARIANT_IE ? `MCG_IMPL_IE : `MCG_IMPL_B;
    localparam logic [31:0] RESET_VAL = VARIANT_IE ? `MCG_RESET_IE : `MCG_RESET_B;
    localparam int          ABSENT_BIT = VARIANT_IE ? `MCG_BIT_FIELDBUS_B : `MCG_BIT_FIELDBUS_IE;

    module_clock_gating_pkg::gate_state_t st;
    module_clock_gating_pkg::gate_state_t next_st;

    logic        cpu_hit;
    logic        mcu_hit;
    logic [31:0] wmask;

    // ==========================================================
    // decode and update
    always_comb begin
        cpu_hit = (cpu_req_i.addr == `MCG_CPU_GATE_ADDR);
        mcu_hit = (mcu_req_i.addr == `MCG_MCU_GATE_ADDR);
        wmask   = `MCG_ALL_ONES;
        next_st = st;
        next_st.cpu.ack = 1'b0;
        next_st.mcu.ack = 1'b0;
        // simultaneous writes from both ports both take effect; clearing commutes
        if (cpu_hit && cpu_req_i.wr) begin
            wmask = wmask & cpu_req_i.wdata;
        end
        if (mcu_hit && mcu_req_i.wr) begin
            wmask = wmask & mcu_req_i.wdata;
        end
        // anding with the held value makes a cleared bit sticky until reset
        next_st.gate = (st.gate & wmask & IMPL_MASK) | `MCG_RSVD_ONES;
        // reads show the value before any same-cycle write
        if (cpu_hit && (cpu_req_i.rd || cpu_req_i.wr)) begin
            next_st.cpu.ack   = 1'b1;
            next_st.cpu.rdata = st.gate;
        end
        if (mcu_hit && (mcu_req_i.rd || mcu_req_i.wr)) begin
            next_st.mcu.ack   = 1'b1;
            next_st.mcu.rdata = st.gate;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st.gate <= RESET_VAL;
            st.cpu  <= '0;
            st.mcu  <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cpu_rsp_o = st.cpu;
    assign mcu_rsp_o = st.mcu;
    // modules must not be touched while their enable is low; nothing here blocks that
    assign gate_en_o = st.gate[`MCG_GATE_W-1:0];

    // ==========================================================
    // checks
    sequence cpu_clear_s(int b);
        cpu_hit && cpu_req_i.wr && !cpu_req_i.wdata[b];
    endsequence

    sequence stays_off_s(int b);
        !gate_en_o[b] [*4];
    endsequence

    property mcu_decode_p;
        @(posedge clk_i) disable iff (sys_rst_i)
        (mcu_req_i.rd && mcu_req_i.addr == `MCG_MCU_GATE_ADDR)
            |=> (mcu_rsp_o.ack && mcu_rsp_o.rdata == $past(st.gate));
    endproperty
    mcu_decode_a: assert property (mcu_decode_p)
        else $error("mcu read of gate register not answered");

    property cpu_decode_p;
        @(posedge clk_i) disable iff (sys_rst_i)
        (cpu_req_i.rd && cpu_req_i.addr == `MCG_CPU_GATE_ADDR)
            |=> (cpu_rsp_o.ack && cpu_rsp_o.rdata == $past(st.gate));
    endproperty
    cpu_decode_a: assert property (cpu_decode_p)
        else $error("cpu read of gate register not answered");

    cpu_miss_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (cpu_req_i.addr != `MCG_CPU_GATE_ADDR) |=> !cpu_rsp_o.ack)
        else $error("cpu access to other address answered");

    property clear_stops_p;
        @(posedge clk_i) disable iff (sys_rst_i)
        cpu_clear_s(`MCG_BIT_WATCHDOG) |=> stays_off_s(`MCG_BIT_WATCHDOG);
    endproperty
    clear_stops_a: assert property (clear_stops_p)
        else $error("watchdog clock not stopped after clear");

    rsvd_high_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cpu_rsp_o.ack |-> (cpu_rsp_o.rdata & `MCG_RSVD_HI_MASK) == 32'h0000_0000)
        else $error("reserved high bits read nonzero");

    rsvd_bit12_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        mcu_rsp_o.ack |-> (mcu_rsp_o.rdata & `MCG_RSVD_B12_MASK) == 32'h0000_0000)
        else $error("reserved bit 12 read nonzero");

    rsvd_ones_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cpu_rsp_o.ack |-> (cpu_rsp_o.rdata & `MCG_RSVD_ONES) == `MCG_RSVD_ONES)
        else $error("reserved ones field read wrong");

    absent_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !gate_en_o[ABSENT_BIT])
        else $error("absent controller gate bit set");

    sticky_stop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (gate_en_o & ~$past(gate_en_o)) == '0)
        else $error("stopped clock restarted without reset");

    reset_value_a: assert property (@(posedge clk_i)
        ($past(sys_rst_i) && !sys_rst_i) |-> st.gate == RESET_VAL)
        else $error("gate register reset value wrong");

    // a write that clears no bit still set must leave the register as it was
    property ones_ignored_p;
        @(posedge clk_i) disable iff (sys_rst_i)
        (cpu_hit && cpu_req_i.wr && ((st.gate & ~cpu_req_i.wdata & IMPL_MASK) == '0)
            && !(mcu_hit && mcu_req_i.wr)) |=> st.gate == $past(st.gate);
    endproperty
    ones_ignored_a: assert property (ones_ignored_p)
        else $error("write of ones changed gate register");

    // ==========================================================
    // second port, cpu bit-12 and absent-bit reads, held read data and write effects
    sequence mcu_clear_s(int b);
        mcu_hit && mcu_req_i.wr && !mcu_req_i.wdata[b];
    endsequence

    sequence quiet_s;
        !(cpu_hit && cpu_req_i.wr) && !(mcu_hit && mcu_req_i.wr);
    endsequence

    property mcu_clear_stops_p;
        @(posedge clk_i) disable iff (sys_rst_i)
        mcu_clear_s(`MCG_BIT_FIELDBUS_A) |=> stays_off_s(`MCG_BIT_FIELDBUS_A);
    endproperty
    mcu_clear_stops_a: assert property (mcu_clear_stops_p)
        else $error("fieldbus clock not stopped after clear");

    mcu_miss_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (mcu_req_i.addr != `MCG_MCU_GATE_ADDR) |=> !mcu_rsp_o.ack)
        else $error("mcu access to other address answered");

    mcu_rsvd_high_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        mcu_rsp_o.ack |-> (mcu_rsp_o.rdata & `MCG_RSVD_HI_MASK) == 32'h0000_0000)
        else $error("reserved high bits read nonzero on mcu port");

    cpu_rsvd_bit12_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cpu_rsp_o.ack |-> (cpu_rsp_o.rdata & `MCG_RSVD_B12_MASK) == 32'h0000_0000)
        else $error("reserved bit 12 read nonzero on cpu port");

    mcu_rsvd_ones_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        mcu_rsp_o.ack |-> (mcu_rsp_o.rdata & `MCG_RSVD_ONES) == `MCG_RSVD_ONES)
        else $error("reserved ones field read wrong on mcu port");

    cpu_absent_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cpu_rsp_o.ack |-> !cpu_rsp_o.rdata[ABSENT_BIT])
        else $error("absent controller bit read as one on cpu port");

    mcu_absent_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        mcu_rsp_o.ack |-> !mcu_rsp_o.rdata[ABSENT_BIT])
        else $error("absent controller bit read as one on mcu port");

    cpu_rdata_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !cpu_rsp_o.ack |-> $stable(cpu_rsp_o.rdata))
        else $error("cpu read data moved without an answer");

    mcu_rdata_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !mcu_rsp_o.ack |-> $stable(mcu_rsp_o.rdata))
        else $error("mcu read data moved without an answer");

    property cpu_clears_p;
        @(posedge clk_i) disable iff (sys_rst_i)
        (cpu_hit && cpu_req_i.wr && !(mcu_hit && mcu_req_i.wr))
            |=> (st.gate & ~$past(cpu_req_i.wdata) & IMPL_MASK) == '0;
    endproperty
    cpu_clears_a: assert property (cpu_clears_p)
        else $error("cpu write of zero left a gate bit set");

    property both_clear_p;
        @(posedge clk_i) disable iff (sys_rst_i)
        (cpu_hit && cpu_req_i.wr && mcu_hit && mcu_req_i.wr)
            |=> (st.gate & ~($past(cpu_req_i.wdata) & $past(mcu_req_i.wdata)) & IMPL_MASK) == '0;
    endproperty
    both_clear_a: assert property (both_clear_p)
        else $error("same-cycle writes did not both clear");

    property quiet_hold_p;
        @(posedge clk_i) disable iff (sys_rst_i)
        quiet_s |=> st.gate == $past(st.gate);
    endproperty
    quiet_hold_a: assert property (quiet_hold_p)
        else $error("gate register changed without a write");

endmodule // module_clock_gating

// File: verif/tb.sv
// self-checking bench for the module clock gating block, bit-14 variant
// assumes the defs header is in the include path and the package is compiled first
`timescale 1ns/1ps
`include "module_clock_gating_defs.svh"

module tb;
    typedef struct packed {
        logic        cv;
        logic        mv;
        logic        w;
        logic [31:0] ca;
        logic [31:0] cd;
        logic [31:0] ma;
        logic [31:0] md;
    } row_t;

    localparam logic [31:0] CA  = `MCG_CPU_GATE_ADDR;
    localparam logic [31:0] MA  = `MCG_MCU_GATE_ADDR;
    localparam logic [31:0] Z   = 32'h0000_0000;
    localparam logic [31:0] RST = `MCG_RESET_IE;
    localparam int          N   = 12;
    localparam row_t        IDLE = '0;
    // ==========================================================
    // rows go out back to back: each is taken at the edge that launches the next
    // gate writes keep reserved and absent bits at their legal values, except the mcu write of all zeros in ROWS[10]
    // no gated module is ever touched by this bench
    localparam row_t ROWS [N] = '{
        '{1'b1, 1'b0, 1'b0, CA, Z, Z, Z},
        '{1'b0, 1'b1, 1'b0, Z, Z, MA, Z},
        '{1'b1, 1'b0, 1'b1, CA, 32'h0000_6FDF, Z, Z},
        '{1'b0, 1'b1, 1'b0, Z, Z, MA, Z},
        '{1'b1, 1'b0, 1'b1, CA, 32'h0000_6FDE, Z, Z},
        '{1'b1, 1'b0, 1'b1, CA, 32'h0000_6FDF, Z, Z},
        '{1'b1, 1'b0, 1'b1, CA, 32'h0000_6FCE, Z, Z},
        '{1'b1, 1'b0, 1'b1, CA + 32'h0000_0004, Z, Z, Z},
        '{1'b0, 1'b1, 1'b1, Z, Z, CA, Z},
        '{1'b1, 1'b1, 1'b1, CA, 32'h0000_6FCC, MA, 32'h0000_4FCE},
        '{1'b0, 1'b1, 1'b1, Z, Z, MA, Z},
        '{1'b1, 1'b0, 1'b0, CA, Z, Z, Z}
    };

    logic                              clk_i = 1'b0;
    logic                              sys_rst_i;
    module_clock_gating_pkg::reg_req_t cpu_req;
    module_clock_gating_pkg::reg_req_t mcu_req;
    module_clock_gating_pkg::reg_rsp_t cpu_rsp;
    module_clock_gating_pkg::reg_rsp_t mcu_rsp;
    logic [`MCG_GATE_W-1:0]            gate_en_o;
    logic [31:0]                       exp_gate;
    int                                n_fail = 0;
    int                                checked = 0;

    always #10 clk_i = ~clk_i;

    module_clock_gating module_clock_gating_i (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .cpu_req_i (cpu_req),
        .mcu_req_i (mcu_req),
        .cpu_rsp_o (cpu_rsp),
        .mcu_rsp_o (mcu_rsp),
        .gate_en_o (gate_en_o)
    );

    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic drive(input row_t r);
        cpu_req <= '{r.ca, r.cv & r.w, r.cv & ~r.w, r.cd};
        mcu_req <= '{r.ma, r.mv & r.w, r.mv & ~r.w, r.md};
    endtask

    task automatic check(input row_t r);
        logic hc;
        logic hm;
        hc = r.cv && (r.ca === CA);
        hm = r.mv && (r.ma === MA);
        chk({31'h0, cpu_rsp.ack}, {31'h0, hc});
        chk({31'h0, mcu_rsp.ack}, {31'h0, hm});
        if (hc) chk(cpu_rsp.rdata, exp_gate);
        if (hm) chk(mcu_rsp.rdata, exp_gate);
        if (r.w && hc) exp_gate = exp_gate & r.cd;
        if (r.w && hm) exp_gate = exp_gate & r.md;
        exp_gate = (exp_gate & `MCG_IMPL_IE) | `MCG_RSVD_ONES;
        chk({17'h0, gate_en_o}, exp_gate);
    endtask

    task automatic run(input int lo, input int hi);
        for (int k = lo; k <= hi + 1; k++) begin
            @(posedge clk_i);
            drive(k <= hi ? ROWS[k] : IDLE);
            #1;
            if (k > lo) check(ROWS[k-1]);
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==========================================================
    // watchdog: the whole run needs well under a hundred cycles
    initial begin
        #20000;
        n_fail++;
        finish_test;
    end

    initial begin
        sys_rst_i = 1'b1;
        cpu_req   = '0;
        mcu_req   = '0;
        repeat (16) @(posedge clk_i);
        #1;
        chk({17'h0, gate_en_o}, RST);
        @(posedge clk_i) sys_rst_i <= 1'b0;
        exp_gate = RST;
        run(0, N - 1);
        $display("table test done");
        // a stopped clock only comes back through reset, applied mid-run here
        @(posedge clk_i) sys_rst_i <= 1'b1;
        #1;
        chk({17'h0, gate_en_o}, RST);
        chk({31'h0, cpu_rsp.ack}, Z);
        @(posedge clk_i) sys_rst_i <= 1'b0;
        exp_gate = RST;
        run(4, 5);
        $display("reset test done");
        finish_test;
    end
endmodule // tb
